/* File: oms_mode_select.sv */
// Overview of operation
// (RQ1) Read-only signed 8-bit indicator shows mode in effect, same encoding.
// (RQ2) Supported: 0,1,3,4,6,8,9,10; values 2,7, negatives, 11 up unsupported.
// (RQ3) A newly written supported value switches the operating mode.
// (RQ4) Master updates mode select and mode cyclic objects together.
// (RQ5) Objects not supported by the new mode are indeterminate afterward.
// (RQ6) Mode change takes about 2 ms; indicator not valid meanwhile.
// (RQ7) Master changes mode only with the motor stopped.
// (RQ8) Select and indicator both zero at enable command raises mode fault; the code raises it only while the indicator is valid.
// (RQ9) Writing zero after a nonzero mode keeps the active mode.
// (RQ10) Writing an unsupported mode value raises the mode fault; the code raises it for non-service writes only.
// (RQ11) Full-closed control: velocity and torque modes raise the mode fault.
// (RQ12) Standard two-degree variant: torque modes fault, unless later edition.
// (RQ13) Sync two-degree variant: velocity modes fault; older edition: torque.
// (RQ14) Mode select resets to zero at power-on.
// (RQ15) Service write of unsupported value is aborted as out of range.
`timescale 1ns/1ps
`default_nettype none
`include "oms_defs.svh"

module oms_mode_select #(
   parameter int unsigned CHG_CYCLES = `OMS_CHG_CYCLES
) (
   // Clock and reset
   input  wire logic               i_clk,
   input  wire logic               i_arst_n,
   // Master writes and power-drive command
   input  wire oms_pkg::oms_sel_wr_t i_sel_wr,
   input  wire logic               i_op_enable_cmd,
   input  wire logic               i_fault_clr,
   // Drive configuration
   input  wire oms_pkg::oms_cfg_t  i_cfg,
   // Mode objects and status
   output logic [7:0]              o_mode_sel,
   output logic [7:0]              o_mode_ind,
   output logic                    o_ind_valid,
   output logic                    o_mode_fault,
   output logic                    o_sdo_abort
);

   localparam int CW = $clog2(CHG_CYCLES + 1);
   localparam logic [CW-1:0] CNT_LAST = CW'(CHG_CYCLES - 1);

   // (RQ2) Supported value decode
   function automatic logic mode_ok(input logic [7:0] v);
      unique case (v)
         `OMS_MODE_NONE, `OMS_MODE_PROF_POS, `OMS_MODE_PROF_VEL,
         `OMS_MODE_TORQUE_PROF, `OMS_MODE_HOMING, `OMS_MODE_CYC_POS,
         `OMS_MODE_CYC_VEL, `OMS_MODE_CYC_TORQUE: mode_ok = 1'b1;
         default: mode_ok = 1'b0;
      endcase
   endfunction

   function automatic logic is_vel(input logic [7:0] v);
      is_vel = (v == `OMS_MODE_PROF_VEL) || (v == `OMS_MODE_CYC_VEL);
   endfunction

   function automatic logic is_trq(input logic [7:0] v);
      is_trq = (v == `OMS_MODE_TORQUE_PROF) || (v == `OMS_MODE_CYC_TORQUE);
   endfunction

   // Combination check against drive configuration
   function automatic logic combo_bad(input logic [7:0] v,
                                      input oms_pkg::oms_cfg_t c);
      logic bad;
      bad = 1'b0;
      // (RQ11) Full-closed limits
      if (c.full_closed && (is_vel(v) || is_trq(v)))
         bad = 1'b1;
      // (RQ12) Standard variant torque
      if (c.tdof_std && !c.ed_std_torque_ok && is_trq(v))
         bad = 1'b1;
      // (RQ13) Sync variant by edition
      if (c.tdof_sync && (c.ed_sync_old ? is_trq(v) : is_vel(v)))
         bad = 1'b1;
      combo_bad = bad;
   endfunction

   logic                rst_s1_r;
   logic                rst_n_r;
   oms_pkg::oms_state_t state_r;
   logic [CW-1:0]       cnt_r;
   logic [7:0]          pend_r;
   logic                unsup;
   logic                bad;
   logic                take;
   logic                op_fault;

   // Reset release through two flops
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rst_s1_r <= 1'b0;
         rst_n_r  <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n_r  <= rst_s1_r;
      end
   end

   // Write classification
   always_comb begin
      unsup = i_sel_wr.wr && !mode_ok(i_sel_wr.val);
      bad   = i_sel_wr.wr && mode_ok(i_sel_wr.val) &&
              combo_bad(i_sel_wr.val, i_cfg);
      // (RQ9) Zero keeps mode
      // (RQ3) New supported nonzero value
      take  = i_sel_wr.wr && !unsup && !bad &&
              (i_sel_wr.val != `OMS_MODE_NONE) &&
              (i_sel_wr.val != pend_r);
      // (RQ8) Nothing selected at enable
      op_fault = i_op_enable_cmd && (o_mode_sel == `OMS_MODE_NONE) &&
                 (o_mode_ind == `OMS_MODE_NONE) && o_ind_valid;
   end

   // Mode select object
   always_ff @(posedge i_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         // (RQ14) Power-on value zero
         o_mode_sel <= `OMS_SEL_RESET;
      end else if (i_sel_wr.wr && !(unsup && i_sel_wr.sdo)) begin
         // (RQ15) Aborted service write not stored
         o_mode_sel <= i_sel_wr.val;
      end
   end

   // Mode change sequencing
   always_ff @(posedge i_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         state_r     <= oms_pkg::OMS_ST_IDLE;
         cnt_r       <= '0;
         pend_r      <= `OMS_IND_RESET;
         o_mode_ind  <= `OMS_IND_RESET;
         o_ind_valid <= 1'b1;
      end else if (take) begin
         // (RQ6) Restart settle time
         state_r     <= oms_pkg::OMS_ST_CHANGE;
         cnt_r       <= '0;
         pend_r      <= i_sel_wr.val;
         // (RQ6) Mode indicator not valid
         o_ind_valid <= 1'b0;
      end else begin
         unique case (state_r)
            oms_pkg::OMS_ST_IDLE: begin
               cnt_r <= '0;
            end
            oms_pkg::OMS_ST_CHANGE: begin
               if (cnt_r == CNT_LAST) begin
                  // (RQ1) Indicator takes new mode
                  state_r     <= oms_pkg::OMS_ST_IDLE;
                  o_mode_ind  <= pend_r;
                  o_ind_valid <= 1'b1;
               end else begin
                  cnt_r <= cnt_r + 1'b1;
               end
            end
         endcase
      end
   end

   // Mode fault, set wins over clear
   always_ff @(posedge i_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         o_mode_fault <= 1'b0;
      end else if ((unsup && !i_sel_wr.sdo) || bad || op_fault) begin
         // (RQ10) Unsupported or forbidden
         o_mode_fault <= 1'b1;
      end else if (i_fault_clr) begin
         o_mode_fault <= 1'b0;
      end
   end

   // Service abort pulse
   always_ff @(posedge i_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         o_sdo_abort <= 1'b0;
      end else begin
         // (RQ15) Out of range answer
         o_sdo_abort <= unsup && i_sel_wr.sdo;
      end
   end

   a_zero_holds: assert property ( // RQ9
      @(posedge i_clk) disable iff (!rst_n_r)
      (i_sel_wr.wr && i_sel_wr.val == `OMS_MODE_NONE && o_ind_valid &&
       state_r == oms_pkg::OMS_ST_IDLE)
      |=> (o_mode_ind == $past(o_mode_ind)) && o_ind_valid)
      else $error("zero write changed active mode");

   a_unsup_fault: assert property ( // RQ10
      @(posedge i_clk) disable iff (!rst_n_r)
      (i_sel_wr.wr && !i_sel_wr.sdo && !mode_ok(i_sel_wr.val))
      |=> o_mode_fault)
      else $error("unsupported mode did not fault");

   a_sdo_abort: assert property ( // RQ15
      @(posedge i_clk) disable iff (!rst_n_r)
      (i_sel_wr.wr && i_sel_wr.sdo && !mode_ok(i_sel_wr.val))
      |=> o_sdo_abort && $stable(o_mode_sel))
      else $error("service write not aborted");

   a_closed_loop: assert property ( // RQ11
      @(posedge i_clk) disable iff (!rst_n_r)
      (i_sel_wr.wr && i_cfg.full_closed &&
       (is_vel(i_sel_wr.val) || is_trq(i_sel_wr.val)))
      |=> o_mode_fault && $stable(pend_r))
      else $error("full-closed combination accepted");

   a_tdof_std: assert property ( // RQ12
      @(posedge i_clk) disable iff (!rst_n_r)
      (i_sel_wr.wr && i_cfg.tdof_std && !i_cfg.ed_std_torque_ok &&
       is_trq(i_sel_wr.val)) |=> o_mode_fault)
      else $error("standard variant torque accepted");

   a_tdof_sync: assert property ( // RQ13
      @(posedge i_clk) disable iff (!rst_n_r)
      (i_sel_wr.wr && i_cfg.tdof_sync && !i_cfg.ed_sync_old &&
       is_vel(i_sel_wr.val)) |=> o_mode_fault)
      else $error("sync variant velocity accepted");

   a_enable_empty: assert property ( // RQ8
      @(posedge i_clk) disable iff (!rst_n_r)
      (i_op_enable_cmd && o_mode_sel == `OMS_MODE_NONE &&
       o_mode_ind == `OMS_MODE_NONE && o_ind_valid) |=> o_mode_fault)
      else $error("enable with no mode did not fault");

   a_change_start: assert property ( // RQ3
      @(posedge i_clk) disable iff (!rst_n_r)
      take |=> !o_ind_valid && pend_r == $past(i_sel_wr.val))
      else $error("mode change not started");

   a_change_done: assert property ( // RQ6
      @(posedge i_clk) disable iff (!rst_n_r)
      $rose(o_ind_valid) |-> $past(cnt_r) == CNT_LAST &&
                             o_mode_ind == pend_r)
      else $error("indicator valid before settle time");

   a_sel_reset: assert property ( // RQ14
      @(posedge i_clk) $rose(rst_n_r) |-> o_mode_sel == `OMS_SEL_RESET)
      else $error("select not zero after reset");

   c_change: cover property (@(posedge i_clk) disable iff (!rst_n_r)
      $rose(o_ind_valid));
   c_fault: cover property (@(posedge i_clk) disable iff (!rst_n_r)
      $rose(o_mode_fault));
   c_abort: cover property (@(posedge i_clk) disable iff (!rst_n_r)
      o_sdo_abort);

endmodule
`default_nettype wire

/* File: oms_defs.svh */
`ifndef OMS_DEFS_SVH
`define OMS_DEFS_SVH

// Mode indicator object index
`define OMS_IND_OFFSET        16'h6061
// Mode select object index
`define OMS_SEL_OFFSET        16'h6060
`define OMS_SEL_RESET         8'h00
`define OMS_IND_RESET         8'h00

// Mode value encoding
`define OMS_MODE_NONE         8'h00
`define OMS_MODE_PROF_POS     8'h01
`define OMS_MODE_PLAIN_VEL    8'h02
`define OMS_MODE_PROF_VEL     8'h03
`define OMS_MODE_TORQUE_PROF  8'h04
`define OMS_MODE_HOMING       8'h06
`define OMS_MODE_INTERP_POS   8'h07
`define OMS_MODE_CYC_POS      8'h08
`define OMS_MODE_CYC_VEL      8'h09
`define OMS_MODE_CYC_TORQUE   8'h0A

// Mode change settle time
`define OMS_CHG_TIME_US       2000
`define OMS_CLK_MHZ           20
`define OMS_CHG_CYCLES        (`OMS_CHG_TIME_US * `OMS_CLK_MHZ)

`endif

/* File: oms_pkg.sv */
`default_nettype none

package oms_pkg;

   typedef enum logic {
      OMS_ST_IDLE,
      OMS_ST_CHANGE
   } oms_state_t;

   // One mode select write from the master
   typedef struct packed {
      logic       wr;
      logic       sdo;
      logic [7:0] val;
   } oms_sel_wr_t;

   // Drive configuration that restricts modes
   typedef struct packed {
      logic full_closed;
      logic tdof_std;
      logic tdof_sync;
      logic ed_std_torque_ok;
      logic ed_sync_old;
   } oms_cfg_t;

endpackage

`default_nettype wire

/* File: oms_master_model.sv */
`timescale 1ns/1ps
`default_nettype none

module oms_master_model (
   // Clock
   input  wire logic                  i_clk,
   // Mode select writes toward the drive
   output var  oms_pkg::oms_sel_wr_t  o_sel_wr
);

   initial o_sel_wr = 10'h000;

   task automatic write_mode(input logic [7:0] val, input logic sdo);
      @(negedge i_clk);
      o_sel_wr <= '{wr: 1'b1, sdo: sdo, val: val};
      @(negedge i_clk);
      // Released lines show the inverse, never a stale copy
      o_sel_wr <= '{wr: 1'b0, sdo: ~sdo, val: ~val};
   endtask

endmodule

`default_nettype wire

/* File: testbench.sv */
`timescale 1ns/1ps
`default_nettype none

module testbench;
   localparam int CHG = 8;
   logic                 clk;
   logic                 arst_n;
   logic                 op_en;
   logic                 flt_clr;
   oms_pkg::oms_cfg_t    cfg;
   oms_pkg::oms_sel_wr_t sel_wr;
   logic [7:0]           mode_sel;
   logic [7:0]           mode_ind;
   logic                 ind_valid;
   logic                 mode_fault;
   logic                 sdo_abort;
   int                   error_cnt;
   int                   cmp_count;
   int                   cyc;

   oms_master_model master_u (.i_clk(clk), .o_sel_wr(sel_wr));

   oms_mode_select #(.CHG_CYCLES(CHG)) dut_u (
      .i_clk(clk), .i_arst_n(arst_n), .i_sel_wr(sel_wr),
      .i_op_enable_cmd(op_en), .i_fault_clr(flt_clr), .i_cfg(cfg),
      .o_mode_sel(mode_sel), .o_mode_ind(mode_ind),
      .o_ind_valid(ind_valid), .o_mode_fault(mode_fault),
      .o_sdo_abort(sdo_abort));

   always #25 clk = ~clk;

   // Whole run needs well under a thousand cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         error_cnt++;
         complete_run();
      end
   end

   task automatic complete_run;
      $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic chk(input logic ok, input string msg);
      cmp_count++;
      if (ok !== 1'b1) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask

   task automatic clr;
      flt_clr = 1'b1;
      @(negedge clk);
      flt_clr = 1'b0;
      chk(mode_fault === 1'b0, "fault clear");
   endtask

   task automatic en(input logic ef);
      op_en = 1'b1;
      @(negedge clk);
      op_en = 1'b0;
      chk(mode_fault === ef, "enable fault");
      if (ef) clr();
   endtask

   // One write, then wait out any change under a bound
   task automatic wr(input logic [7:0] v, input logic s, input logic [7:0] es,
                     input logic [7:0] ei, input logic ef, input logic ea);
      logic [7:0] prev;
      int         n;
      prev = mode_ind;
      n = 0;
      master_u.write_mode(v, s);
      chk(mode_sel === es, "select value");
      chk(mode_fault === ef, "mode fault");
      chk(sdo_abort === ea, "service abort");
      chk(ind_valid === (ei == prev), "valid drop");
      while (ind_valid !== 1'b1 && n < CHG + 4) begin
         @(negedge clk);
         n++;
      end
      chk(mode_ind === ei && ind_valid === 1'b1, "indicator");
      if (ei != prev) chk(n == CHG, "change time");
      if (ef) clr();
   endtask

   task automatic t_reset;
      chk(mode_sel === 8'h00 && mode_ind === 8'h00, "reset modes");
      chk(ind_valid === 1'b1 && mode_fault === 1'b0, "reset flags");
      en(1'b1);
      $display("t_reset done");
   endtask

   task automatic t_modes;
      logic [7:0] ok_m [7] = '{8'h01, 8'h03, 8'h04, 8'h06,
                               8'h08, 8'h09, 8'h0A};
      foreach (ok_m[i]) wr(ok_m[i], 1'b0, ok_m[i], ok_m[i], 1'b0, 1'b0);
      wr(8'h00, 1'b0, 8'h00, 8'h0A, 1'b0, 1'b0);
      en(1'b0);
      $display("t_modes done");
   endtask

   task automatic t_unsup;
      logic [7:0] bad [6] = '{8'h02, 8'h07, 8'h80, 8'hFF, 8'h0B, 8'h7F};
      foreach (bad[i]) wr(bad[i], 1'b1, 8'h00, 8'h0A, 1'b0, 1'b1);
      foreach (bad[i]) wr(bad[i], 1'b0, bad[i], 8'h0A, 1'b1, 1'b0);
      $display("t_unsup done");
   endtask

   task automatic t_combo;
      logic [4:0]  cf [14] = '{5'h10, 5'h10, 5'h10, 5'h10, 5'h10, 5'h08,
                               5'h08, 5'h08, 5'h0A, 5'h04, 5'h04, 5'h04,
                               5'h05, 5'h05};
      logic [7:0]  vv [14] = '{8'h03, 8'h04, 8'h09, 8'h0A, 8'h08, 8'h04,
                               8'h0A, 8'h03, 8'h04, 8'h03, 8'h09, 8'h01,
                               8'h04, 8'h03};
      logic [13:0] fv = 14'h3D9A;
      logic [7:0]  cur;
      logic [7:0]  nm;
      wr(8'h01, 1'b0, 8'h01, 8'h01, 1'b0, 1'b0);
      cur = 8'h01;
      for (int i = 0; i < 14; i++) begin
         cfg = cf[i];
         nm = fv[13-i] ? cur : vv[i];
         wr(vv[i], i[0], vv[i], nm, fv[13-i], 1'b0);
         cur = nm;
      end
      $display("t_combo done");
   endtask

   // Reset in mid-run must drop a live mode
   task automatic t_power;
      @(negedge clk);
      arst_n = 1'b0;
      repeat (2) @(negedge clk);
      arst_n = 1'b1;
      repeat (3) @(negedge clk);
      chk(mode_sel === 8'h00 && mode_ind === 8'h00, "power modes");
      chk(ind_valid === 1'b1 && mode_fault === 1'b0, "power flags");
      en(1'b1);
      wr(8'h01, 1'b0, 8'h01, 8'h01, 1'b0, 1'b0);
      $display("t_power done");
   endtask

   initial begin
      clk = 1'b0;
      arst_n = 1'b0;
      op_en = 1'b0;
      flt_clr = 1'b0;
      cfg = 5'h00;
      error_cnt = 0;
      cmp_count = 0;
      cyc = 0;
      repeat (2) @(negedge clk);
      arst_n = 1'b1;
      repeat (3) @(negedge clk);
      t_reset();
      t_modes();
      t_unsup();
      t_combo();
      t_power();
      complete_run();
   end
endmodule

`default_nettype wire
